// ### rass_defs.vh
// Constants for the addressed serial switch: line timing and command characters.
// Assumes the including file uses them with the widths noted beside each.
`ifndef RASS_DEFS_VH
`define RASS_DEFS_VH

// System clock rate in hertz (250 MHz, 4 ns period).
`define RASS_CLOCK_HZ      250000000
// Addressing link rate in baud.
`define RASS_CMD_BAUD      9600
// Cycles per bit at the addressing rate, rounded down.
`define RASS_BIT_CYCLES    (`RASS_CLOCK_HZ / `RASS_CMD_BAUD)
// Data bits per character on the addressing link.
`define RASS_DATA_BITS     8
// Station address after reset, before the switch setting is sampled.
`define RASS_ADDR_RESET    8'h00
// Command framing characters.
`define RASS_CHAR_XOFF     8'h13
`define RASS_CHAR_SOH      8'h01
// ASCII anchors for hex digit decoding.
`define RASS_CHAR_ZERO     8'h30
`define RASS_CHAR_NINE     8'h39
`define RASS_CHAR_UPPER_A  8'h41
`define RASS_CHAR_UPPER_F  8'h46
`define RASS_CHAR_LOWER_A  8'h61
`define RASS_CHAR_LOWER_F  8'h66
// Added to the low nibble of a letter digit (upper or lower case) to give its value.
`define RASS_LETTER_ADJ    4'h9
// Bit times in one character frame: start, eight data bits and stop.
`define RASS_FRAME_BITS    10

`endif

// ### rass_rx.v
// Character receiver for the addressing link: 8 data bits, no parity, 1 stop bit.
// Assumes the line input is already synchronous to i_clock and idles high.
`timescale 1ns/1ps
`default_nettype none
`include "rass_defs.vh"

module rass_rx #(
  parameter integer P_BIT_CYCLES = `RASS_BIT_CYCLES,
  parameter integer P_CNT_WIDTH  = 16
) (
  input  wire       i_clock,
  input  wire       i_nrst,
  input  wire       i_line,
  output reg  [7:0] o_data,
  output reg        o_valid,
  output reg        o_frame_err
);

  localparam [3:0] S_IDLE  = 4'b0001;
  localparam [3:0] S_START = 4'b0010;
  localparam [3:0] S_DATA  = 4'b0100;
  localparam [3:0] S_STOP  = 4'b1000;

  localparam integer           C_FULL_I = P_BIT_CYCLES - 1;
  localparam integer           C_HALF_I = (P_BIT_CYCLES / 2) - 1;
  localparam [P_CNT_WIDTH-1:0] C_FULL   = C_FULL_I[P_CNT_WIDTH-1:0];
  localparam [P_CNT_WIDTH-1:0] C_HALF   = C_HALF_I[P_CNT_WIDTH-1:0];

  reg [3:0]             state;
  reg [P_CNT_WIDTH-1:0] count;
  reg [2:0]             bit_idx;
  reg [7:0]             shift;

  ////////////////////////////////////////////////////////////////////////////////
  // Every bit is sampled at its centre; a low stop bit flags a framing error,
  // which is what a character sent at a foreign rate usually produces.
  always @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      state       <= S_IDLE;
      count       <= {P_CNT_WIDTH{1'b0}};
      bit_idx     <= 3'd0;
      shift       <= 8'h00;
      o_data      <= 8'h00;
      o_valid     <= 1'b0;
      o_frame_err <= 1'b0;
    end else begin
      o_valid     <= 1'b0;
      o_frame_err <= 1'b0;
      case (state)
        S_IDLE: begin
          if (!i_line) begin
            state <= S_START;
            count <= C_HALF;
          end
        end
        S_START: begin
          if (count != {P_CNT_WIDTH{1'b0}}) begin
            count <= count - 1'b1;
          end else if (!i_line) begin
            state   <= S_DATA;
            count   <= C_FULL;
            bit_idx <= 3'd0;
          end else begin
            state <= S_IDLE;
          end
        end
        S_DATA: begin
          if (count != {P_CNT_WIDTH{1'b0}}) begin
            count <= count - 1'b1;
          end else begin
            shift <= {i_line, shift[7:1]};
            count <= C_FULL;
            if (bit_idx == 3'd7) begin
              state <= S_STOP;
            end
            bit_idx <= bit_idx + 1'b1;
          end
        end
        S_STOP: begin
          if (count != {P_CNT_WIDTH{1'b0}}) begin
            count <= count - 1'b1;
          end else begin
            state <= S_IDLE;
            if (i_line) begin
              o_data  <= shift;
              o_valid <= 1'b1;
            end else begin
              o_frame_err <= 1'b1;
            end
          end
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end

endmodule

`default_nettype wire

// ### rass_switch.v
// Addressed RS485-to-RS232 transparent switch: command decoder and pass-through paths.
// Assumes all line inputs are synchronous to i_clock and the station switch is static.
`timescale 1ns/1ps
`default_nettype none
`include "rass_defs.vh"

module rass_switch #(
  parameter integer P_BIT_CYCLES = `RASS_BIT_CYCLES,
  parameter integer P_CNT_WIDTH  = 16
) (
  input  wire       i_clock,
  input  wire       i_nrst,
  input  wire [7:0] i_station_addr,
  input  wire       i_four_wire,
  input  wire       i_bus_rx,
  output reg        o_bus_tx,
  output reg        o_bus_tx_oe,
  input  wire       i_dev_rx,
  output reg        o_dev_tx,
  output reg        o_selected
);

  localparam [3:0] P_WAIT_XOFF = 4'b0001;
  localparam [3:0] P_WAIT_HI   = 4'b0010;
  localparam [3:0] P_WAIT_LO   = 4'b0100;
  localparam [3:0] P_WAIT_SOH  = 4'b1000;

  localparam integer       C_GAP_W = P_CNT_WIDTH + 4;
  localparam integer       C_GAP_I = `RASS_FRAME_BITS * P_BIT_CYCLES;
  localparam [C_GAP_W-1:0] C_GAP   = C_GAP_I[C_GAP_W-1:0];

  reg  [7:0] station;
  reg  [3:0] pstate;
  reg  [3:0] hi_nib;
  reg  [7:0] cmd_addr;
  wire [7:0] rx_data;
  wire       rx_valid;
  wire       rx_frame_err;
  wire       rx_line;
  reg  [4:0] digit;
  reg  [C_GAP_W-1:0] gap_count;
  reg                resync;
  wire               gap_done;
  wire               char_ok;
  reg                next_dev_tx;
  reg                next_bus_tx;
  reg                next_bus_tx_oe;

  ////////////////////////////////////////////////////////////////////////////////
  // Station address, caught by a clocked process after the reset release.
  always @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      station <= `RASS_ADDR_RESET;
    end else begin
      station <= i_station_addr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // In two-wire mode the bus echoes our own drive; the decoder must not hear it.
  assign rx_line = (o_bus_tx_oe && !i_four_wire) ? 1'b1 : i_bus_rx;

  rass_rx #(
    .P_BIT_CYCLES (P_BIT_CYCLES),
    .P_CNT_WIDTH  (P_CNT_WIDTH)
  ) u_rx (
    .i_clock     (i_clock),
    .i_nrst      (i_nrst),
    .i_line      (rx_line),
    .o_data      (rx_data),
    .o_valid     (rx_valid),
    .o_frame_err (rx_frame_err)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // After a framing error the receiver may lock onto a data edge of a
  // foreign-rate character, so decoded characters are ignored until the line
  // has stayed idle for a whole character time.
  assign gap_done = (gap_count == C_GAP);
  assign char_ok  = rx_valid && !resync;

  always @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      gap_count <= {C_GAP_W{1'b0}};
    end else if (!rx_line) begin
      gap_count <= {C_GAP_W{1'b0}};
    end else if (!gap_done) begin
      gap_count <= gap_count + 1'b1;
    end
  end

  always @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      resync <= 1'b0;
    end else if (rx_frame_err) begin
      resync <= 1'b1;
    end else if (gap_done) begin
      resync <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Hex digit decode; bit 4 set marks a character that is not a digit.
  always @* begin
    digit = 5'h10;
    if (rx_data >= `RASS_CHAR_ZERO && rx_data <= `RASS_CHAR_NINE) begin
      digit = {1'b0, rx_data[3:0]};
    end else if (rx_data >= `RASS_CHAR_UPPER_A && rx_data <= `RASS_CHAR_UPPER_F) begin
      digit = {1'b0, rx_data[3:0] + `RASS_LETTER_ADJ};
    end else if (rx_data >= `RASS_CHAR_LOWER_A && rx_data <= `RASS_CHAR_LOWER_F) begin
      digit = {1'b0, rx_data[3:0] + `RASS_LETTER_ADJ};
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Command decoder. Any framing error or unexpected character restarts the
  // search, so a command sent at a foreign rate never completes.
  always @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      pstate     <= P_WAIT_XOFF;
      hi_nib     <= 4'h0;
      cmd_addr   <= 8'h00;
      o_selected <= 1'b0;
    end else if (rx_frame_err) begin
      pstate <= P_WAIT_XOFF;
    end else if (char_ok) begin
      case (pstate)
        P_WAIT_XOFF: begin
          if (rx_data == `RASS_CHAR_XOFF) begin
            pstate <= P_WAIT_HI;
          end
        end
        P_WAIT_HI: begin
          if (!digit[4]) begin
            hi_nib <= digit[3:0];
            pstate <= P_WAIT_LO;
          end else if (rx_data == `RASS_CHAR_XOFF) begin
            pstate <= P_WAIT_HI;
          end else begin
            pstate <= P_WAIT_XOFF;
          end
        end
        P_WAIT_LO: begin
          if (!digit[4]) begin
            cmd_addr <= {hi_nib, digit[3:0]};
            pstate   <= P_WAIT_SOH;
          end else if (rx_data == `RASS_CHAR_XOFF) begin
            pstate <= P_WAIT_HI;
          end else begin
            pstate <= P_WAIT_XOFF;
          end
        end
        P_WAIT_SOH: begin
          if (rx_data == `RASS_CHAR_SOH) begin
            o_selected <= (cmd_addr == station);
            pstate     <= P_WAIT_XOFF;
          end else if (rx_data == `RASS_CHAR_XOFF) begin
            pstate <= P_WAIT_HI;
          end else begin
            pstate <= P_WAIT_XOFF;
          end
        end
        default: begin
          pstate <= P_WAIT_XOFF;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Pass-through paths: one register stage each, no rate dependence and no
  // storage of characters. Unselected, both outputs idle high and the bus
  // driver stays off so other switches can answer.
  always @* begin
    next_dev_tx    = 1'b1;
    next_bus_tx    = 1'b1;
    next_bus_tx_oe = 1'b0;
    if (o_selected) begin
      next_dev_tx = (o_bus_tx_oe && !i_four_wire) ? 1'b1 : i_bus_rx;
      next_bus_tx = i_dev_rx;
      if (i_four_wire) begin
        next_bus_tx_oe = 1'b1;
      end else begin
        next_bus_tx_oe = !i_dev_rx;
      end
    end
  end

  always @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      o_dev_tx    <= 1'b1;
      o_bus_tx    <= 1'b1;
      o_bus_tx_oe <= 1'b0;
    end else begin
      o_dev_tx    <= next_dev_tx;
      o_bus_tx    <= next_bus_tx;
      o_bus_tx_oe <= next_bus_tx_oe;
    end
  end

endmodule

`default_nettype wire

// ### rass_switch_sva.sv
// Checker for the addressed serial switch, watching the top module ports.
// Assumes the bind hands on the bit length used by the instance.
`timescale 1ns/1ps
`default_nettype none
`include "rass_defs.vh"
module rass_switch_sva #(
  parameter integer P_BIT_CYCLES = `RASS_BIT_CYCLES,
  parameter integer P_CNT_WIDTH  = 16
) (
  input wire logic       i_clock,
  input wire logic       i_nrst,
  input wire logic [7:0] i_station_addr,
  input wire logic       i_four_wire,
  input wire logic       i_bus_rx,
  input wire logic       o_bus_tx,
  input wire logic       o_bus_tx_oe,
  input wire logic       i_dev_rx,
  input wire logic       o_dev_tx,
  input wire logic       o_selected
);
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_nrst);
  // Counts cycles since the bus line was last low, holding at 1000.
  int quiet;
  always @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) quiet <= 0;
    else if (!i_bus_rx) quiet <= 0;
    else if (quiet < 1000) quiet <= quiet + 1;
  end
  wire both_sel = o_selected;
  a_reset_idle: assert property ($rose(i_nrst) |-> !o_selected && o_bus_tx && o_dev_tx)
    else $error("outputs not idle after reset");
  a_idle_unsel: assert property (!both_sel && !$past(o_selected)
    |-> o_dev_tx && o_bus_tx && !o_bus_tx_oe)
    else $error("unselected switch is not idle");
  a_bus_fwd: assert property (both_sel && $past(o_selected) |-> o_bus_tx == $past(i_dev_rx))
    else $error("device data not forwarded");
  a_dev_fwd: assert property (both_sel && $past(o_selected) && $past(i_four_wire)
    |-> o_dev_tx == $past(i_bus_rx))
    else $error("bus data not forwarded");
  a_oe_four: assert property (both_sel && $past(o_selected) && $past(i_four_wire)
    |-> o_bus_tx_oe)
    else $error("four-wire driver not enabled");
  a_oe_two: assert property (both_sel && $past(o_selected) && !$past(i_four_wire)
    |-> o_bus_tx_oe == !$past(i_dev_rx))
    else $error("two-wire driver enable wrong");
  a_sel_stop: assert property ($changed(o_selected) |-> $past(i_bus_rx) && $past(i_bus_rx, 3))
    else $error("selection changed outside a stop bit");
  a_sel_quiet: assert property ($changed(o_selected) |-> quiet < 10 * P_BIT_CYCLES)
    else $error("selection changed without a command");
  c_sel: cover property ($rose(o_selected));
  c_desel: cover property ($fell(o_selected));
  c_drive: cover property ($rose(o_bus_tx_oe));
endmodule
bind rass_switch rass_switch_sva #(.P_BIT_CYCLES(P_BIT_CYCLES), .P_CNT_WIDTH(P_CNT_WIDTH)) chk (
  .i_clock(i_clock), .i_nrst(i_nrst), .i_station_addr(i_station_addr),
  .i_four_wire(i_four_wire), .i_bus_rx(i_bus_rx), .o_bus_tx(o_bus_tx),
  .o_bus_tx_oe(o_bus_tx_oe), .i_dev_rx(i_dev_rx), .o_dev_tx(o_dev_tx),
  .o_selected(o_selected));
`default_nettype wire

// ### rass_host.sv
// Host model driving the shared RS485 line with 8N1 characters.
// Assumes callers start it on the bench clock; the line idles high.
`timescale 1ns/1ps
`default_nettype none
module rass_host (
  input  wire logic i_clock,
  output var  logic o_line
);
  initial o_line = 1'b1;
  function automatic logic [7:0] hexc(input logic [3:0] d, input logic lc);
    return d < 4'ha ? 8'h30 + d : (lc ? 8'h61 : 8'h41) + d - 8'h0a;
  endfunction
  task automatic send(input logic [7:0] c, input int n);
    logic [9:0] f;
    f = {1'b1, c, 1'b0};
    @(posedge i_clock);
    for (int b = 0; b < 10; b++) begin
      o_line <= f[b];
      repeat (n) @(posedge i_clock);
    end
  endtask
  task automatic address(input logic [7:0] a, input logic lc, input int n);
    send(8'h13, n);
    send(hexc(a[7:4], lc), n);
    send(hexc(a[3:0], lc), n);
    send(8'h01, n);
  endtask
endmodule
`default_nettype wire

// ### test_rs485_addressed_serial_switch.sv
// Self-checking bench for the addressed serial switch with a host model.
// Assumes the definitions header and design sources are compiled first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin errors++; \
  $display("unexpected at %0t: got %h expected %h", $time, g, e); end end
module test_rs485_addressed_serial_switch;
  localparam integer P = 16;
  logic       i_clock = 1'b0;
  logic       i_nrst = 1'b0;
  logic [7:0] i_station_addr = 8'h00;
  logic       i_four_wire = 1'b1;
  logic       i_dev_rx = 1'b1;
  logic       prev;
  wire logic  host_line;
  wire logic  o_bus_tx, o_bus_tx_oe, o_dev_tx, o_selected;
  int         errors = 0;
  int         checks_done = 0;
  int         cycles = 0;
  // In two-wire mode the pair carries whoever is driving it.
  wire logic  i_bus_rx = (!i_four_wire && o_bus_tx_oe) ? o_bus_tx : host_line;
  always #2 i_clock = ~i_clock;
  rass_host host (.i_clock(i_clock), .o_line(host_line));
  rass_switch #(.P_BIT_CYCLES(P)) dut (.i_clock(i_clock), .i_nrst(i_nrst),
    .i_station_addr(i_station_addr), .i_four_wire(i_four_wire), .i_bus_rx(i_bus_rx),
    .o_bus_tx(o_bus_tx), .o_bus_tx_oe(o_bus_tx_oe), .i_dev_rx(i_dev_rx),
    .o_dev_tx(o_dev_tx), .o_selected(o_selected));
  task print_verdict;
    if (errors == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task t_addr;
    host.address(8'h00, 1'b0, P); `CHK(o_selected, 1'b1)
    host.address(8'h3c, 1'b0, P); `CHK(o_selected, 1'b0)
    @(posedge i_clock) i_station_addr <= 8'ha5;
    host.address(8'ha5, 1'b0, 2 * P);
    repeat (16 * P) @(posedge i_clock);
    `CHK(o_selected, 1'b0)
    host.address(8'ha5, 1'b1, P); `CHK(o_selected, 1'b1)
    @(posedge i_clock) i_station_addr <= 8'hff;
    host.address(8'ha5, 1'b0, P); `CHK(o_selected, 1'b0)
    host.address(8'hff, 1'b0, P); `CHK(o_selected, 1'b1)
  endtask
  task t_pass;
    for (int k = 0; k < 8; k++) begin
      @(posedge i_clock) i_dev_rx <= k[0] ^ k[2];
      @(posedge i_clock) #1 `CHK({o_bus_tx, o_bus_tx_oe}, {k[0] ^ k[2], 1'b1})
    end
    fork
      host.send(8'h5a, P / 2);
      repeat (5 * P) begin
        @(posedge i_clock) prev = i_bus_rx;
        #1 `CHK(o_dev_tx, prev)
      end
    join
  endtask
  task t_two;
    @(posedge i_clock) i_four_wire <= 1'b0;
    for (int k = 0; k < 4; k++) begin
      @(posedge i_clock) i_dev_rx <= k[0];
      @(posedge i_clock) #1 `CHK(o_bus_tx_oe, !k[0])
    end
    @(posedge i_clock) i_four_wire <= 1'b1;
  endtask
  always @(posedge i_clock) begin
    cycles++;
    if (cycles == 30000) begin
      errors++;
      print_verdict();
    end
  end
  initial begin
    repeat (5) @(posedge i_clock);
    i_nrst <= 1'b1;
    @(posedge i_clock) #1 `CHK({o_selected, o_bus_tx, o_bus_tx_oe, o_dev_tx}, 4'h5)
    t_addr();
    t_pass();
    t_two();
    print_verdict();
  end
endmodule
`default_nettype wire
